//--- hdl/pwm_power_stage_config.sv
// PWM power stage configuration, desaturation logic, blanking and dead time
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/10ps
module pwm_power_stage_config import pwm_stage_pkg::*; (
	input wire logic CLK,
	input wire logic RST,
	input wire logic [13:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [7:0] RDATA,
	input wire logic DESAT_CMP_RAW,
	input wire logic WATCHDOG,
	input wire logic PRIMARY_PWM,
	input wire logic SECONDARY_PWM,
	input wire logic PRIMARY_CURRENT_TRIP,
	output logic PRIMARY_GATE_OUT,
	output logic SECONDARY_GATE_OUT,
	output logic CURRENT_TRIP_OUT,
	output logic DESAT_PWM_TERMINATE,
	output logic PWM_RESET,
	output logic DESAT_EVENT_FLAG,
	output analog_cfg_s ANALOG_CFG,
	output logic [7:0] DESAT_TRIM,
	output logic [1:0] BLANKING_CODE
);
	// Reset-undefined registers are cleared here so simulation never sees X
	logic [7:0] ov_q, desat_q, cur_q, blank_q, slope_q, dead_q, trim_q, byp_q;
	logic flag_q, status_q, status_d, status_prev_q;
	logic wr_ov, wr_desat, wr_cur, wr_blank, wr_slope, wr_dead, wr_trim, wr_byp;
	logic rise_ev, fall_ev;
	logic p_pwm_prev_q;
	logic [3:0] blank_cnt_q, blank_len;
	logic [7:0] p_cnt_q, s_cnt_q;
	logic [7:0] p_len, s_len;

	function automatic logic [7:0] dead_cycles(input logic [3:0] code);
		int ps;
		ps = (int'(code) + 1) * DEAD_STEP_PS;
		dead_cycles = 8'((ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
	endfunction

	assign wr_ov = WR && ADDR == ADDR_OV_LEVEL;
	assign wr_desat = WR && ADDR == ADDR_DESAT_CTRL;
	assign wr_cur = WR && ADDR == ADDR_CUR_OFFSET;
	assign wr_blank = WR && ADDR == ADDR_BLANKING;
	assign wr_slope = WR && ADDR == ADDR_SLOPE;
	assign wr_dead = WR && ADDR == ADDR_DEADTIME;
	assign wr_trim = WR && ADDR == ADDR_TRIM;
	assign wr_byp = WR && ADDR == ADDR_BYPASS;

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			ov_q <= CFG_RESET;
			desat_q <= DESAT_CTRL_RESET;
			cur_q <= CFG_RESET;
			blank_q <= CFG_RESET;
			slope_q <= CFG_RESET;
			dead_q <= CFG_RESET;
			trim_q <= CFG_RESET;
			byp_q <= CFG_RESET;
		end else begin
			if (wr_ov) begin
				ov_q <= WDATA;
			end
			if (wr_desat) begin
				desat_q <= WDATA & DESAT_WR_MASK;
			end
			if (wr_cur) begin
				cur_q <= WDATA & CUR_OFFSET_MASK;
			end
			if (wr_blank) begin
				blank_q <= WDATA & BLANKING_MASK;
			end
			if (wr_slope) begin
				slope_q <= WDATA & SLOPE_MASK;
			end
			if (wr_dead) begin
				dead_q <= WDATA;
			end
			if (wr_trim) begin
				trim_q <= WDATA;
			end
			if (wr_byp) begin
				byp_q <= WDATA & 8'h30;
			end
		end
	end

	// Comparator status after polarity; raw input assumed already synchronous
	assign status_d = DESAT_CMP_RAW ^ desat_q[BIT_POL];

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			status_q <= 1'b0;
			status_prev_q <= 1'b0;
		end else begin
			status_q <= status_d;
			status_prev_q <= status_q;
		end
	end

	assign rise_ev = desat_q[BIT_RISE] && status_q && !status_prev_q;
	assign fall_ev = desat_q[BIT_FALL] && !status_q && status_prev_q;

	// Set wins over a same-cycle software clear
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			flag_q <= 1'b0;
		end else if (rise_ev || fall_ev) begin
			flag_q <= 1'b1;
		end else if (WR && ADDR == ADDR_CAL_WORD + 14'h0001 && WDATA[BIT_FLAG]) begin
			flag_q <= 1'b0;
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			DESAT_PWM_TERMINATE <= 1'b0;
			PWM_RESET <= 1'b0;
			DESAT_EVENT_FLAG <= 1'b0;
			ANALOG_CFG <= '0;
			DESAT_TRIM <= 8'h00;
			BLANKING_CODE <= 2'b00;
		end else begin
			DESAT_PWM_TERMINATE <= desat_q[BIT_OE] && status_q;
			PWM_RESET <= desat_q[BIT_WDE] && WATCHDOG;
			DESAT_EVENT_FLAG <= flag_q;
			ANALOG_CFG.ov_level_code <= ov_q;
			ANALOG_CFG.current_offset_code <= cur_q[3:0];
			ANALOG_CFG.slope_rate_code <= slope_q[5:0];
			ANALOG_CFG.slope_active <= !slope_q[BIT_SLOPE_BYPASS];
			ANALOG_CFG.desat_input_select <= desat_q[BIT_MUX];
			DESAT_TRIM <= trim_q;
			BLANKING_CODE <= blank_q[1:0];
		end
	end

	always_comb begin
		case (blank_q[1:0])
			2'b01: blank_len = BLANK_CYC_1;
			2'b10: blank_len = BLANK_CYC_2;
			2'b11: blank_len = BLANK_CYC_3;
			default: blank_len = 4'h0;
		endcase
	end

	// Blanking window starts at primary turn-on request
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			p_pwm_prev_q <= 1'b0;
			blank_cnt_q <= 4'h0;
			CURRENT_TRIP_OUT <= 1'b0;
		end else begin
			p_pwm_prev_q <= PRIMARY_PWM;
			if (PRIMARY_PWM && !p_pwm_prev_q) begin
				blank_cnt_q <= blank_len;
			end else if (blank_cnt_q != 4'h0) begin
				blank_cnt_q <= blank_cnt_q - 4'h1;
			end
			CURRENT_TRIP_OUT <= PRIMARY_CURRENT_TRIP && blank_cnt_q == 4'h0
				&& !(PRIMARY_PWM && !p_pwm_prev_q && blank_len != 4'h0);
		end
	end

	assign p_len = dead_cycles(dead_q[7:4]);
	assign s_len = dead_cycles(dead_q[3:0]);

	// Counters run while the request is high and bypass is clear; falling edge drops the gate at once
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			p_cnt_q <= 8'h00;
			s_cnt_q <= 8'h00;
			PRIMARY_GATE_OUT <= 1'b0;
			SECONDARY_GATE_OUT <= 1'b0;
		end else begin
			if (!PRIMARY_PWM) begin
				p_cnt_q <= 8'h00;
				PRIMARY_GATE_OUT <= 1'b0;
			end else if (byp_q[BIT_P_BYPASS]) begin
				PRIMARY_GATE_OUT <= 1'b1;
			end else if (p_cnt_q >= p_len) begin
				// Dead time comes on top of the register stage, so code 0 still lags bypass
				PRIMARY_GATE_OUT <= 1'b1;
			end else begin
				p_cnt_q <= p_cnt_q + 8'h01;
			end
			if (!SECONDARY_PWM) begin
				s_cnt_q <= 8'h00;
				SECONDARY_GATE_OUT <= 1'b0;
			end else if (byp_q[BIT_S_BYPASS]) begin
				SECONDARY_GATE_OUT <= 1'b1;
			end else if (s_cnt_q >= s_len) begin
				SECONDARY_GATE_OUT <= 1'b1;
			end else begin
				s_cnt_q <= s_cnt_q + 8'h01;
			end
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			RDATA <= 8'h00;
		end else if (RD) begin
			case (ADDR)
				ADDR_OV_LEVEL: RDATA <= ov_q;
				ADDR_DESAT_CTRL: RDATA <= desat_q | {5'h00, status_q, 2'b00};
				ADDR_CUR_OFFSET: RDATA <= cur_q;
				ADDR_BLANKING: RDATA <= blank_q;
				ADDR_SLOPE: RDATA <= slope_q;
				ADDR_DEADTIME: RDATA <= dead_q;
				ADDR_TRIM: RDATA <= trim_q;
				ADDR_BYPASS: RDATA <= byp_q;
				ADDR_CAL_WORD: RDATA <= CAL_WORD_DEFAULT[7:0];
				ADDR_CAL_WORD + 14'h0001: RDATA <= {7'h00, flag_q};
				default: RDATA <= 8'h00;
			endcase
		end else begin
			RDATA <= 8'h00;
		end
	end

	a_rise_flag: assert property (@(posedge CLK) disable iff (RST) rise_ev |=> flag_q) else $error("rise lost");
	a_fall_flag: assert property (@(posedge CLK) disable iff (RST) fall_ev |=> flag_q) else $error("fall lost");
	a_flag_no_oe: assert property (@(posedge CLK) disable iff (RST)
		(!desat_q[BIT_OE] && rise_ev) |-> ##1 flag_q) else $error("flag gated by enable");
	a_pwm_gate: assert property (@(posedge CLK) disable iff (RST)
		!desat_q[BIT_OE] |=> !DESAT_PWM_TERMINATE) else $error("terminate while disabled");
	a_wdog_gate: assert property (@(posedge CLK) disable iff (RST)
		(WATCHDOG && desat_q[BIT_WDE]) |=> PWM_RESET) else $error("watchdog reset missing");
	a_gate_fall: assert property (@(posedge CLK) disable iff (RST)
		!PRIMARY_PWM |=> !PRIMARY_GATE_OUT) else $error("primary fall delayed");
	a_sec_fall: assert property (@(posedge CLK) disable iff (RST)
		!SECONDARY_PWM |=> !SECONDARY_GATE_OUT) else $error("secondary fall delayed");
	a_bypass_fast: assert property (@(posedge CLK) disable iff (RST)
		(PRIMARY_PWM && byp_q[BIT_P_BYPASS]) |=> PRIMARY_GATE_OUT) else $error("bypass not applied");
	a_dead_min: assert property (@(posedge CLK) disable iff (RST)
		($rose(PRIMARY_PWM) && !byp_q[BIT_P_BYPASS]) |=> !PRIMARY_GATE_OUT) else $error("dead time skipped");
	a_blank_hold: assert property (@(posedge CLK) disable iff (RST)
		(blank_cnt_q != 4'h0) |=> !CURRENT_TRIP_OUT) else $error("trip during blanking");
	a_unimpl_zero: assert property (@(posedge CLK) disable iff (RST)
		(RD && ADDR == ADDR_BLANKING) |=> RDATA[7:2] == 6'h00) else $error("reserved bits set");
endmodule

//--- hdl/pwm_stage_pkg.sv
// Constants, register map and carrier types for the PWM power stage block
// Behaviour
// - 8-bit overvoltage level code, reference 2*Vbg*N/255
// - Bit 7 selects bandgap, else sense pin
// - Bit 6 lets watchdog reset the PWM
// - Bit 4 inverts the comparator output
// - Bit 3 lets comparator act on PWM
// - Bit 2 reads comparator after polarity
// - Bit 1 flags rising status edges
// - Bit 0 flags falling status edges
// - Event flag ignores the PWM enable bit
// - 4-bit current offset, 50 mV per step
// - Blanking code selects 0/50/100/200 ns
// - Ignore current sense during blanking after turn-on
// - Slope compensation active while bypass bit clear
// - 6-bit slope rate code N
// - Dead timers active only when bypass clear
// - Separate turn-on dead time per gate
// - Primary dead time 16 ns times code+1
// - Secondary code uses same encoding
// - Unimplemented bits read zero, ignore writes
// - Bypass bits skip dead time, reset zero
package pwm_stage_pkg;
	localparam logic [13:0] ADDR_OV_LEVEL = 14'h0190;
	localparam logic [13:0] ADDR_DESAT_CTRL = 14'h0191;
	localparam logic [13:0] ADDR_CUR_OFFSET = 14'h0192;
	localparam logic [13:0] ADDR_BLANKING = 14'h0193;
	localparam logic [13:0] ADDR_SLOPE = 14'h0194;
	localparam logic [13:0] ADDR_DEADTIME = 14'h0195;
	localparam logic [13:0] ADDR_TRIM = 14'h0196;
	localparam logic [13:0] ADDR_BYPASS = 14'h0197;
	localparam logic [13:0] ADDR_CAL_WORD = 14'h2081;
	localparam int BIT_MUX = 7;
	localparam int BIT_WDE = 6;
	localparam int BIT_POL = 4;
	localparam int BIT_OE = 3;
	localparam int BIT_STATUS = 2;
	localparam int BIT_RISE = 1;
	localparam int BIT_FALL = 0;
	localparam int BIT_SLOPE_BYPASS = 6;
	localparam int BIT_P_BYPASS = 5;
	localparam int BIT_S_BYPASS = 4;
	localparam int BIT_FLAG = 0;
	localparam logic [7:0] DESAT_CTRL_RESET = 8'h00;
	localparam logic [7:0] CFG_RESET = 8'h00;
	localparam logic [13:0] CAL_WORD_DEFAULT = 14'h0000;
	localparam logic [7:0] CUR_OFFSET_MASK = 8'h0f;
	localparam logic [7:0] BLANKING_MASK = 8'h03;
	localparam logic [7:0] SLOPE_MASK = 8'h7f;
	localparam logic [7:0] DESAT_WR_MASK = 8'hdb;
	localparam int CLK_MHZ = 40;
	localparam int CLK_PERIOD_PS = 25000;
	localparam int BLANK_NS_1 = 50;
	localparam int BLANK_NS_2 = 100;
	localparam int BLANK_NS_3 = 200;
	localparam int DEAD_STEP_NS = 16;
	localparam logic [3:0] BLANK_CYC_1 = 4'((BLANK_NS_1 * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
	localparam logic [3:0] BLANK_CYC_2 = 4'((BLANK_NS_2 * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
	localparam logic [3:0] BLANK_CYC_3 = 4'((BLANK_NS_3 * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
	localparam int DEAD_STEP_PS = DEAD_STEP_NS * 1000;

	typedef struct packed {
		logic [7:0] ov_level_code;
		logic [3:0] current_offset_code;
		logic [5:0] slope_rate_code;
		logic slope_active;
		logic desat_input_select;
	} analog_cfg_s;
endpackage

//--- verification/power_train.sv
// Power train stand-in that rings the current sense at switch turn-on
`timescale 1ns/10ps
module power_train (
	input wire logic CLK,
	input wire logic PWM,
	output logic TRIP
);
	logic pwm_q = 1'b0;
	logic [1:0] cnt_q = 2'h0;
	// Spike lasts three cycles, shorter than the longest blanking
	always_ff @(posedge CLK) begin
		pwm_q <= PWM;
		if (PWM && !pwm_q)
			cnt_q <= 2'h3;
		else if (cnt_q != 2'h0)
			cnt_q <= cnt_q - 2'h1;
	end
	assign TRIP = (cnt_q != 2'h0);
endmodule

//--- verification/tb.sv
// Self-checking bench for the power stage configuration block
`timescale 1ns/10ps
`define CHK(n, e, s) begin checked++; if ((e) !== (s)) begin err_total++; \
	$display("CHECK FAILED %s exp %h got %h", n, e, s); end end
module tb import pwm_stage_pkg::*;;
	logic clk = 1'b0, rst = 1'b1, wr_s = 1'b0, rd_s = 1'b0, raw = 1'b0, wdog = 1'b0;
	logic ppwm = 1'b0, spwm = 1'b0, trip, pg, sg, trip_o, term, pres, flag;
	logic [13:0] addr = 14'h0;
	logic [7:0] wdata = 8'h0, rdata, q, trim;
	logic [1:0] blank;
	analog_cfg_s cfg;
	int err_total = 0, checked = 0, n, e;
	pwm_power_stage_config dut (.CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr_s),
		.RD(rd_s), .RDATA(rdata), .DESAT_CMP_RAW(raw), .WATCHDOG(wdog), .PRIMARY_PWM(ppwm),
		.SECONDARY_PWM(spwm), .PRIMARY_CURRENT_TRIP(trip), .PRIMARY_GATE_OUT(pg),
		.SECONDARY_GATE_OUT(sg), .CURRENT_TRIP_OUT(trip_o), .DESAT_PWM_TERMINATE(term),
		.PWM_RESET(pres), .DESAT_EVENT_FLAG(flag), .ANALOG_CFG(cfg), .DESAT_TRIM(trim),
		.BLANKING_CODE(blank));
	power_train stage (.CLK(clk), .PWM(ppwm), .TRIP(trip));
	initial begin
		forever #12.5 clk = ~clk;
	end
	task automatic wr(input logic [13:0] a, input logic [7:0] d);
		@(posedge clk) begin addr <= a; wdata <= d; wr_s <= 1'b1; end
		@(posedge clk) wr_s <= 1'b0;
	endtask
	task automatic rd(input logic [13:0] a);
		@(posedge clk) begin addr <= a; rd_s <= 1'b1; end
		@(posedge clk) rd_s <= 1'b0;
		#1 q = rdata;
	endtask
	task automatic idle(input int c);
		repeat (c) @(posedge clk);
		#1;
	endtask
	// Dead time in whole clock cycles, rounded up
	function automatic int dt(input logic [3:0] c);
		return (DEAD_STEP_PS * (c + 1) + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	endfunction
	task automatic gate(input bit s, input logic [3:0] c, input bit byp);
		wr(14'h195, s ? {4'h0, c} : {c, 4'h0});
		wr(14'h197, {2'h0, !s & byp, s & byp, 4'h0});
		e = byp ? 1 : dt(c) + 1;
		@(posedge clk) if (s) spwm <= 1'b1; else ppwm <= 1'b1;
		n = 0;
		do begin idle(1); n++; end while ((s ? sg : pg) !== 1'b1 && n < 40);
		`CHK("gate rise", 1'b1, n >= e && n <= e + (byp ? 1 : 3))
		`CHK("other gate", 1'b0, s ? pg : sg)
		@(posedge clk) begin spwm <= 1'b0; ppwm <= 1'b0; end
		idle(2);
		`CHK("gate fall", 1'b0, s ? sg : pg)
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		#200000;
		err_total++;
		tally_and_finish();
	end
	initial begin
		void'($urandom(35054));
		idle(10);
		@(posedge clk) rst <= 1'b0;
		rd(14'h191);
		`CHK("ctrl reset", 8'h00, q)
		`CHK("slope reset", 1'b1, cfg.slope_active)
		rd(14'h197);
		`CHK("bypass reset", 8'h00, q)
		for (int i = 0; i < 12; i++) begin
			logic [7:0] m[4] = '{8'hff, 8'h0f, 8'h03, 8'h7f};
			logic [7:0] d;
			d = (i < 4) ? 8'hff : 8'($urandom);
			wr(14'h190 + 14'(i % 4 == 0 ? 0 : i % 4 + 1), d);
			rd(14'h190 + 14'(i % 4 == 0 ? 0 : i % 4 + 1));
			`CHK("masked reg", d & m[i % 4], q)
		end
		wr(14'h190, 8'ha5);
		wr(14'h194, 8'h40);
		idle(1);
		`CHK("ov code", 8'ha5, cfg.ov_level_code)
		`CHK("slope bypass", 1'b0, cfg.slope_active)
		rd(14'h100);
		`CHK("unmapped", 8'h00, q)
		rd(14'h2081);
		wr(14'h196, q ^ 8'h3c);
		idle(1);
		`CHK("trim", 8'h3c, trim)
		for (int i = 0; i < 4; i++) begin
			wr(14'h191, {3'h4, i[1], 4'h8});
			@(posedge clk) raw <= i[0];
			idle(4);
			rd(14'h191);
			`CHK("status", i[0] ^ i[1], q[BIT_STATUS])
			`CHK("terminate", i[0] ^ i[1], term)
			`CHK("mux", 1'b1, cfg.desat_input_select)
		end
		wr(14'h191, 8'h00);
		idle(3);
		`CHK("oe off", 1'b0, term)
		for (int i = 0; i < 2; i++) begin
			wr(14'h191, {1'b0, i[0], 6'h0});
			@(posedge clk) wdog <= 1'b1;
			idle(3);
			`CHK("pwm reset", i[0], pres)
			@(posedge clk) wdog <= 1'b0;
		end
		for (int i = 0; i < 4; i++) begin
			wr(14'h191, {6'h0, i[1], !i[1]});
			@(posedge clk) raw <= i[1] ? !i[0] : i[0];
			idle(6);
			wr(14'h2082, 8'h01);
			@(posedge clk) raw <= i[1] ? i[0] : !i[0];
			idle(6);
			rd(14'h2082);
			`CHK("edge flag", i[0], q[BIT_FLAG])
			`CHK("flag out", i[0], flag)
		end
		for (int i = 0; i < 4; i++)
			gate(i[0], i[1] ? 4'hf : 4'h0, 1'b0);
		gate(1'b0, 4'($urandom), 1'b1);
		gate(1'b1, 4'hf, 1'b1);
		for (int i = 0; i < 2; i++) begin
			wr(14'h193, i[0] ? 8'h03 : 8'h00);
			@(posedge clk) ppwm <= 1'b1;
			n = 0;
			repeat (6) begin idle(1); n = n | trip_o; end
			`CHK("blanking", !i[0], n[0])
			@(posedge clk) ppwm <= 1'b0;
			idle(2);
		end
		$display("tests done");
		tally_and_finish();
	end
endmodule
